// [ccs_host_model.sv]
// Host model that drives the byte-wide register strobe port
`timescale 1ns/10ps
module ccs_host_model (
    input  wire logic       sys_clk_in,
    input  wire logic [7:0] rdata_in,
    output logic [4:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    initial begin
        addr_out = 5'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        v[0] = (a == 5'h0b) ? 1'b1 : v[0];
        v[7] = (a == 5'h0e) ? 1'b0 : v[7];
        v[7:6] = (a == 5'h11) ? 2'b00 : v[7:6];
        v[0] = (a == 5'h15) ? 1'b0 : v[0];
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= v;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
    endtask

    // count written, then read back with no gap
    task automatic wr_rd_byte(input logic [4:0] a, input logic [7:0] w, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= w;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_byte(input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
endmodule

// [ccs_pkg.sv]
// Package for the clock synthesizer control bytes 7 to 21
package ccs_pkg;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [4:0] IDX_IDENT    = 5'h07;
    localparam logic [4:0] IDX_VIDEO_EN = 5'h08;
    localparam logic [4:0] IDX_TEST_SW  = 5'h09;
    localparam logic [4:0] IDX_CPU_STOP = 5'h0a;
    localparam logic [4:0] IDX_PROD_ONE = 5'h0b;
    localparam logic [4:0] IDX_BLK_LEN  = 5'h0c;
    localparam logic [4:0] IDX_MFG_TEST = 5'h0d;
    localparam logic [4:0] IDX_RSV_14   = 5'h0e;
    localparam logic [4:0] IDX_RSV_15   = 5'h0f;
    localparam logic [4:0] IDX_RSV_16   = 5'h10;
    localparam logic [4:0] IDX_PANEL    = 5'h11;
    localparam logic [4:0] IDX_RSV_18   = 5'h12;
    localparam logic [4:0] IDX_RSV_19   = 5'h13;
    localparam logic [4:0] IDX_DRIVE    = 5'h14;
    localparam logic [4:0] IDX_PROD_0   = 5'h15;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_VIDEO_PLAIN   = 1;
    localparam int BIT_VIDEO_SPREAD  = 0;
    localparam int BIT_BUS5_STOP     = 7;
    localparam int BIT_REF_DRIVE     = 5;
    localparam int BIT_TEST_REF      = 4;
    localparam int BIT_TEST_MODE     = 3;
    localparam int BIT_SWING_HI      = 2;
    localparam int BIT_PANEL_PIN     = 7;
    localparam int BIT_CPU1_STOP     = 1;
    localparam int BIT_CPU0_STOP     = 0;
    localparam int BIT_BLK_HI        = 5;
    localparam int BIT_PANEL_FREQ    = 2;
    localparam int BIT_DRV_USB       = 7;
    localparam int BIT_DRV_BUS5      = 4;
    localparam int BIT_DRV_BUS34     = 2;
    localparam int BIT_DRV_BUS02     = 0;

    // Writable masks; zero bits are read-only
    localparam logic [7:0] WMASK_VIDEO_EN = 8'h0f;
    localparam logic [7:0] WMASK_TEST_SW  = 8'hbf;
    localparam logic [7:0] WMASK_CPU_STOP = 8'h7f;
    localparam logic [7:0] WMASK_FULL     = 8'hff;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_VIDEO_EN = 8'h13;
    localparam logic [7:0] RST_TEST_SW  = 8'h25;
    localparam logic [7:0] RST_CPU_STOP = 8'h03;
    localparam logic [7:0] RST_PROD_ONE = 8'h01;
    localparam logic [7:0] RST_BLK_LEN  = 8'h0d;
    localparam logic [7:0] RST_RSV_18   = 8'h06;
    localparam logic [7:0] RST_DRIVE    = 8'h6a;
    localparam logic [7:0] RST_ZERO     = 8'h00;

    // Number of stored bytes, 8 to 21
    localparam int NUM_STORED = 14;

    typedef struct packed {
        logic [NUM_STORED-1:0][7:0] regs;
        logic [7:0]                 rdata;
    } ccs_state_s;

    typedef struct packed {
        logic       video_plain_en;
        logic       video_spread_en;
        logic       bus5_stop_qual;
        logic       ref_drive_double;
        logic       test_mode;
        logic       test_drive_ref;
        logic [2:0] swing_code;
        logic       cpu1_stop_qual;
        logic       cpu0_stop_qual;
        logic [5:0] block_read_count;
        logic       panel_freq_96;
        logic       usb_drive_high;
        logic       bus5_drive_high;
        logic       bus34_drive_high;
        logic       bus02_drive_high;
    } ccs_ctrl_s;

endpackage

// [ccs_regs.sv]
// Control and status bytes 7 to 21 of the clock synthesizer
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module ccs_regs
    import ccs_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [3:0] REVISION_CODE = 4'h1,
    parameter logic [3:0] VENDOR_CODE   = 4'h5,
    parameter int         ADDR_WIDTH    = 5
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  resetn_in,
    input  wire logic [ADDR_WIDTH-1:0] addr_in,
    input  wire logic [7:0]            wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    input  wire logic                  panel_clock_select_pin_in,
    output logic [7:0]                 rdata_out,
    output ccs_ctrl_s                  ctrl_out
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (ADDR_WIDTH < 5) begin : g_bad_addr
        $error("ADDR_WIDTH must be at least 5");
    end

    if (NUM_STORED != 32'(IDX_PROD_0) - 32'(IDX_VIDEO_EN) + 1) begin : g_bad_count
        $error("NUM_STORED must cover bytes 8 to 21");
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    ccs_state_s state_q;
    ccs_state_s state_d;

    logic [NUM_STORED-1:0][7:0] reset_vals;
    logic [NUM_STORED-1:0][7:0] wmask;
    logic [NUM_STORED-1:0]      hit;
    logic [7:0]                 rd_mux;
    logic                       addr_hi_zero;

    always_comb begin
        reset_vals     = '0;
        reset_vals[0]  = RST_VIDEO_EN;
        reset_vals[1]  = RST_TEST_SW;
        reset_vals[2]  = RST_CPU_STOP;
        reset_vals[3]  = RST_PROD_ONE;
        reset_vals[4]  = RST_BLK_LEN;
        reset_vals[10] = RST_RSV_18;
        reset_vals[12] = RST_DRIVE;
        wmask          = {NUM_STORED{WMASK_FULL}};
        wmask[0]       = WMASK_VIDEO_EN;
        wmask[1]       = WMASK_TEST_SW;
        wmask[2]       = WMASK_CPU_STOP;
    end

    if (ADDR_WIDTH > 5) begin : g_hi
        assign addr_hi_zero = (addr_in[ADDR_WIDTH-1:5] == '0);
    end else begin : g_nohi
        assign addr_hi_zero = 1'b1;
    end

    genvar gi;
    for (gi = 0; gi < NUM_STORED; gi++) begin : g_dec
        assign hit[gi] = addr_hi_zero
                         && (addr_in[4:0] == 5'(gi + 32'(IDX_VIDEO_EN)));
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        if (addr_hi_zero && addr_in[4:0] == IDX_IDENT) begin
            rd_mux = {REVISION_CODE, VENDOR_CODE};
        end
        for (int i = 0; i < NUM_STORED; i++) begin
            if (hit[i]) begin
                rd_mux = state_q.regs[i];
            end
        end
        if (hit[2]) begin
            rd_mux[BIT_PANEL_PIN] = panel_clock_select_pin_in;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d       = state_q;
        state_d.rdata = rd_in ? rd_mux : 8'h00;
        for (int i = 0; i < NUM_STORED; i++) begin
            if (wr_in && hit[i]) begin
                state_d.regs[i] = (state_q.regs[i] & ~wmask[i]) | (wdata_in & wmask[i]);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_q.regs  <= reset_vals;
            state_q.rdata <= 8'h00;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_out = state_q.rdata;

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    always_comb begin
        ctrl_out.video_plain_en   = state_q.regs[0][BIT_VIDEO_PLAIN];
        ctrl_out.video_spread_en  = state_q.regs[0][BIT_VIDEO_SPREAD];
        ctrl_out.bus5_stop_qual   = state_q.regs[1][BIT_BUS5_STOP];
        ctrl_out.ref_drive_double = state_q.regs[1][BIT_REF_DRIVE];
        ctrl_out.test_mode        = state_q.regs[1][BIT_TEST_MODE];
        // test output choice, only meaningful in test mode
        ctrl_out.test_drive_ref   = state_q.regs[1][BIT_TEST_MODE]
                                    & state_q.regs[1][BIT_TEST_REF];
        ctrl_out.swing_code       = state_q.regs[1][BIT_SWING_HI:0];
        ctrl_out.cpu1_stop_qual   = state_q.regs[2][BIT_CPU1_STOP];
        ctrl_out.cpu0_stop_qual   = state_q.regs[2][BIT_CPU0_STOP];
        ctrl_out.block_read_count = state_q.regs[4][BIT_BLK_HI:0];
        ctrl_out.panel_freq_96    = state_q.regs[9][BIT_PANEL_FREQ];
        ctrl_out.usb_drive_high   = state_q.regs[12][BIT_DRV_USB];
        ctrl_out.bus5_drive_high  = state_q.regs[12][BIT_DRV_BUS5];
        ctrl_out.bus34_drive_high = state_q.regs[12][BIT_DRV_BUS34];
        ctrl_out.bus02_drive_high = state_q.regs[12][BIT_DRV_BUS02];
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence wr_video_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_VIDEO_EN);
    endsequence

    video_enable_a: assert property (
        wr_video_s |=> ctrl_out.video_plain_en == $past(wdata_in[BIT_VIDEO_PLAIN]))
        else $error("video enable not written");
    bus5_stop_a: assert property (
        wr_in && addr_in == ADDR_WIDTH'(IDX_TEST_SW)
        |=> ctrl_out.bus5_stop_qual == $past(wdata_in[BIT_BUS5_STOP]))
        else $error("bus five stop not written");
    ref_drive_a: assert property (
        !(wr_in && addr_in == ADDR_WIDTH'(IDX_TEST_SW))
        |=> $stable(ctrl_out.ref_drive_double))
        else $error("reference drive changed without write");
    test_ref_a: assert property (
        ctrl_out.test_drive_ref |-> ctrl_out.test_mode)
        else $error("test choice active outside test mode");
    swing_code_a: assert property (
        wr_in && addr_in == ADDR_WIDTH'(IDX_TEST_SW)
        |=> ctrl_out.swing_code == $past(wdata_in[2:0]))
        else $error("swing code not written");
    block_count_a: assert property (
        wr_in && addr_in == ADDR_WIDTH'(IDX_BLK_LEN)
        ##1 rd_in && addr_in == ADDR_WIDTH'(IDX_BLK_LEN)
        |=> rdata_out == $past(wdata_in, 2))
        else $error("block count readback wrong");
    ident_ro_a: assert property (
        rd_in && addr_in == ADDR_WIDTH'(IDX_IDENT)
        |=> rdata_out == {REVISION_CODE, VENDOR_CODE})
        else $error("identification byte wrong");
    pin_status_a: assert property (
        rd_in && addr_in == ADDR_WIDTH'(IDX_CPU_STOP)
        |=> rdata_out[BIT_PANEL_PIN] == $past(panel_clock_select_pin_in))
        else $error("pin status wrong");
    ro_bits_a: assert property (
        wr_video_s |=> state_q.regs[0][7:4] == $past(state_q.regs[0][7:4]))
        else $error("read-only bits changed");

    // ----------------------------------------
    // Bus sequences
    // ----------------------------------------
    sequence wr_test_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_TEST_SW);
    endsequence

    sequence wr_cpu_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_CPU_STOP);
    endsequence

    sequence wr_prod_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_PROD_ONE);
    endsequence

    sequence wr_blk_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_BLK_LEN);
    endsequence

    sequence wr_panel_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_PANEL);
    endsequence

    sequence wr_drive_s;
        wr_in && addr_in == ADDR_WIDTH'(IDX_DRIVE);
    endsequence

    sequence rd_blk_s;
        rd_in && addr_in == ADDR_WIDTH'(IDX_BLK_LEN);
    endsequence

    // Anything outside bytes 7 to 21, upper address bits included
    sequence wr_unmapped_s;
        wr_in && (addr_in < ADDR_WIDTH'(IDX_IDENT) || addr_in > ADDR_WIDTH'(IDX_PROD_0));
    endsequence

    sequence rd_unmapped_s;
        rd_in && (addr_in < ADDR_WIDTH'(IDX_IDENT) || addr_in > ADDR_WIDTH'(IDX_PROD_0));
    endsequence

    sequence released_s;
        $rose(resetn_in);
    endsequence

    // ----------------------------------------
    // Write effects on the control fields
    // ----------------------------------------
    video_spread_a: assert property (
        wr_video_s |=> ctrl_out.video_spread_en == $past(wdata_in[BIT_VIDEO_SPREAD]))
        else $error("spread video enable not written");

    ref_write_a: assert property (
        wr_test_s |=> ctrl_out.ref_drive_double == $past(wdata_in[BIT_REF_DRIVE]))
        else $error("reference drive not written");

    test_mode_a: assert property (
        wr_test_s |=> ctrl_out.test_mode == $past(wdata_in[BIT_TEST_MODE]))
        else $error("test mode not written");

    // The reference choice only counts while test mode is entered
    test_choice_a: assert property (
        wr_test_s |=> ctrl_out.test_drive_ref
                      == $past(wdata_in[BIT_TEST_MODE] & wdata_in[BIT_TEST_REF]))
        else $error("test output choice wrong");

    cpu1_stop_a: assert property (
        wr_cpu_s |=> ctrl_out.cpu1_stop_qual == $past(wdata_in[BIT_CPU1_STOP]))
        else $error("management processor stop not written");

    cpu0_stop_a: assert property (
        wr_cpu_s |=> ctrl_out.cpu0_stop_qual == $past(wdata_in[BIT_CPU0_STOP]))
        else $error("first processor stop not written");

    block_write_a: assert property (
        wr_blk_s |=> ctrl_out.block_read_count == $past(wdata_in[BIT_BLK_HI:0]))
        else $error("block read count not written");

    panel_freq_a: assert property (
        wr_panel_s |=> ctrl_out.panel_freq_96 == $past(wdata_in[BIT_PANEL_FREQ]))
        else $error("panel clock frequency not written");

    usb_drive_a: assert property (
        wr_drive_s |=> ctrl_out.usb_drive_high == $past(wdata_in[BIT_DRV_USB]))
        else $error("48 MHz drive not written");

    bus5_drive_a: assert property (
        wr_drive_s |=> ctrl_out.bus5_drive_high == $past(wdata_in[BIT_DRV_BUS5]))
        else $error("bus clock five drive not written");

    bus34_drive_a: assert property (
        wr_drive_s |=> ctrl_out.bus34_drive_high == $past(wdata_in[BIT_DRV_BUS34]))
        else $error("bus clocks three and four drive not written");

    bus02_drive_a: assert property (
        wr_drive_s |=> ctrl_out.bus02_drive_high == $past(wdata_in[BIT_DRV_BUS02]))
        else $error("bus clocks zero to two drive not written");

    // ----------------------------------------
    // Storage of reserved and read-only bits
    // ----------------------------------------
    prod_store_a: assert property (
        wr_prod_s |=> state_q.regs[3] == $past(wdata_in))
        else $error("production byte not stored");

    blk_spare_a: assert property (
        wr_blk_s |=> state_q.regs[4][7:6] == $past(wdata_in[7:6]))
        else $error("block count spare bits not stored");

    spare_ro_a: assert property (
        wr_test_s |=> state_q.regs[1][6] == $past(state_q.regs[1][6]))
        else $error("read-only spare bit changed");

    // Bit 7 of byte 10 is never stored; the pin is muxed in on read
    pin_ro_a: assert property (
        wr_cpu_s |=> state_q.regs[2][BIT_PANEL_PIN] == $past(state_q.regs[2][BIT_PANEL_PIN]))
        else $error("pin status bit stored");

    unmapped_wr_a: assert property (
        wr_unmapped_s |=> $stable(state_q.regs))
        else $error("unmapped write stored");

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read data stand one cycle only, so a stale byte cannot be taken twice
    read_idle_a: assert property (
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data outside read cycle");

    unmapped_rd_a: assert property (
        rd_unmapped_s |=> rdata_out == 8'h00)
        else $error("unmapped byte read nonzero");

    block_read_a: assert property (
        rd_blk_s |=> rdata_out[BIT_BLK_HI:0] == $past(ctrl_out.block_read_count))
        else $error("block count read differs from field");

    // ----------------------------------------
    // Values at release of reset
    // ----------------------------------------
    reset_video_a: assert property (
        released_s |-> ctrl_out.video_plain_en && ctrl_out.video_spread_en)
        else $error("video enables not set at reset");

    reset_test_a: assert property (
        released_s |-> !ctrl_out.test_mode && !ctrl_out.test_drive_ref
                       && ctrl_out.ref_drive_double == RST_TEST_SW[BIT_REF_DRIVE])
        else $error("test byte reset wrong");

    reset_swing_a: assert property (
        released_s |-> ctrl_out.swing_code == RST_TEST_SW[BIT_SWING_HI:0])
        else $error("swing code reset wrong");

    reset_cpu_a: assert property (
        released_s |-> ctrl_out.cpu1_stop_qual && ctrl_out.cpu0_stop_qual)
        else $error("processor stop qualifiers reset wrong");

    reset_count_a: assert property (
        released_s |-> ctrl_out.block_read_count == RST_BLK_LEN[BIT_BLK_HI:0])
        else $error("block read count reset wrong");

    reset_drive_a: assert property (
        released_s |-> !ctrl_out.usb_drive_high && !ctrl_out.bus5_drive_high
                       && !ctrl_out.bus34_drive_high && !ctrl_out.bus02_drive_high
                       && !ctrl_out.panel_freq_96)
        else $error("drive strengths reset wrong");

endmodule

// [tb_ccs_regs.sv]
// Self-checking testbench for the control bytes 7 to 21
`timescale 1ns/10ps
module tb_ccs_regs
    import ccs_pkg::*;
;
    // Arbitrary identification values
    localparam logic [3:0] REV = 4'h2;
    localparam logic [3:0] VEN = 4'h9;
    logic       sys_clk_in;
    logic       resetn_in;
    logic       pin;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    ccs_ctrl_s  ctrl;
    int         error_cnt;
    int         check_count;
    int         cyc;
    logic [7:0] rst_tab [15] = '{8'h29, 8'h13, 8'h25, 8'h03, 8'h01, 8'h0d, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h6a, 8'h00};
    logic [7:0] ff_tab [15] = '{8'h29, 8'h1f, 8'hbf, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7f,
                                8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hfe};
    logic [7:0] z_tab [15] = '{8'h29, 8'h10, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0] fa [9] = '{5'h08, 5'h09, 5'h0a, 5'h0c, 5'h11, 5'h14, 5'h09, 5'h14, 5'h09};
    logic [7:0] fd [9] = '{8'h02, 8'h98, 8'h01, 8'h2a, 8'h04, 8'h84, 8'h10, 8'h11, 8'h03};
    logic [21:0] fc [9] = '{22'b1001_00_101_11_001101_00000, 22'b1010_11_000_11_001101_00000,
        22'b1010_11_000_01_001101_00000, 22'b1010_11_000_01_101010_00000,
        22'b1010_11_000_01_101010_10000, 22'b1010_11_000_01_101010_11010,
        22'b1000_00_000_01_101010_11010, 22'b1000_00_000_01_101010_10101,
        22'b1000_00_011_01_101010_10101};

    ccs_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN)) u_ccs_regs (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .panel_clock_select_pin_in(pin), .rdata_out(rdata),
        .ctrl_out(ctrl));
    ccs_host_model u_ccs_host_model (
        .sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Every test needs well under this many cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_fill(input logic [7:0] v, input logic [7:0] tab [15]);
        logic [7:0] d;
        for (int a = 7; a <= 21; a++) begin
            u_ccs_host_model.wr_byte(5'(a), v);
        end
        for (int a = 7; a <= 21; a++) begin
            u_ccs_host_model.rd_byte(5'(a), d);
            chk(d, tab[a-7]);
        end
        chk(ctrl, (v == 8'hff) ? 22'h3fffff : 22'h0);
        $display("fill %h done", v);
    endtask

    task automatic t_misc();
        logic [7:0] d;
        @(posedge sys_clk_in);
        pin <= 1'b1;
        u_ccs_host_model.rd_byte(5'h0a, d);
        chk(d, 8'h80);
        @(posedge sys_clk_in);
        pin <= 1'b0;
        u_ccs_host_model.rd_byte(5'h0a, d);
        chk(d, 8'h00);
        u_ccs_host_model.wr_byte(5'h16, 8'hff);
        u_ccs_host_model.rd_byte(5'h16, d);
        chk(d, 8'h00);
        u_ccs_host_model.rd_byte(5'h00, d);
        chk(d, 8'h00);
        u_ccs_host_model.rd_byte(5'h0b, d);
        @(posedge sys_clk_in);
        #1;
        chk(rdata, 8'h00);
        $display("pin and unmapped done");
    endtask

    initial begin
        logic [7:0] d;
        error_cnt = 0;
        check_count = 0;
        resetn_in = 1'b0;
        pin = 1'b0;
        repeat (8) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        for (int a = 7; a <= 21; a++) begin
            u_ccs_host_model.rd_byte(5'(a), d);
            chk(d, rst_tab[a-7]);
        end
        chk(ctrl, 22'b1101_00_101_11_001101_00000);
        $display("reset values done");
        // Count written before any longer block read
        for (int i = 0; i < 9; i++) begin
            u_ccs_host_model.wr_byte(fa[i], fd[i]);
            #1;
            chk(ctrl, fc[i]);
        end
        u_ccs_host_model.rd_byte(5'h0c, d);
        chk(d, 8'h2a);
        u_ccs_host_model.wr_rd_byte(5'h0c, 8'h15, d);
        chk(d, 8'h15);
        chk(ctrl.block_read_count, 6'h15);
        $display("fields done");
        t_fill(8'hff, ff_tab);
        t_fill(8'h00, z_tab);
        t_misc();
        stop_test();
    end
endmodule
